// ===== bench/register_write_checksum_test.sv
// testbench: apb host drives the link into the checksum device
// assumes host makes the link clock; expectations from a local crc model
`timescale 1ns/1ps
module register_write_checksum_test;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready;
	logic pslverr;
	logic err;
	logic standby;
	logic power_down;
	logic reg_rst;
	logic mod_rst;
	logic [7:0] crc_value;
	logic [7:0] xor_value;
	logic [7:0] ec;
	logic [7:0] ex;
	logic [7:0] r;
	logic [7:0] sv;
	logic [7:0] pw [3] = '{8'h10, 8'h11, 8'h01};
	int mismatches = 0;
	int n_tests = 0;
	int n_reg = 0;
	int n_mod = 0;
	int nm;
	rwcs_if lnk();
	rwcs_host u_rwcs_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk));
	rwcs_device u_rwcs_device (.lnk(lnk), .presetn(presetn), .standby(standby),
		.power_down(power_down), .reg_reset_pulse(reg_rst), .mod_reset_pulse(mod_rst),
		.crc_value(crc_value), .xor_value(xor_value));
	rwcs_assertions u_chk (.link_clk(lnk.link_clk), .presetn(presetn), .req_tgl(lnk.req_tgl),
		.rd(lnk.rd), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
		.ack_tgl(lnk.ack_tgl));

	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge lnk.link_clk) begin
		if (reg_rst === 1'h1) n_reg++;
		if (mod_rst === 1'h1) n_mod++;
	end

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] v;
		v = c ^ b;
		for (int i = 0; i < 8; i++) v = v[7] ? {v[6:0], 1'h0} ^ 8'h07 : {v[6:0], 1'h0};
		return v;
	endfunction

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic op(input logic rdb, input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, 12'h000, {15'h0000, rdb, d, a});
		do begin
			apb(1'h0, 12'h004, 32'h0);
		end while (q[0] !== 1'h0);
		r = q[15:8];
	endtask
	task automatic wf(input logic [7:0] a, input logic [7:0] d, input logic fx);
		op(1'h0, a, d);
		ec = crc8(ec, d);
		if (fx) ex = ex ^ d;
	endtask
	task automatic sums();
		chk("crc", crc_value, ec);
		chk("xor", xor_value, ex);
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ec = 8'h00;
		ex = 8'h00;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		sums();
		apb(1'h0, 12'h008, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", q, 32'h0);
		wf(8'h10, 8'h12, 1'h0);
		wf(8'h11, 8'h34, 1'h0);
		sums();
		sv = crc_value;
		repeat (4) op(1'h0, 8'h7e, 8'h00);
		ec = 8'h00;
		sums();
		wf(8'h10, 8'h34, 1'h0);
		wf(8'h11, 8'h12, 1'h0);
		sums();
		chk("order", {31'h0, crc_value != sv}, 32'h1);
		op(1'h1, 8'h10, 8'h00);
		sums();
		wf(8'hc3, 8'h55, 1'h0);
		sums();
		op(1'h0, 8'h00, 8'h03);
		sums();
		op(1'h1, 8'h7e, 8'h00);
		chk("crc any page", r, ec);
		apb(1'h0, 12'h000, 32'h0);
		chk("last command", q, 32'h0001007e);
		op(1'h0, 8'h7f, 8'h8c);
		wf(8'h20, 8'ha5, 1'h1);
		wf(8'h21, 8'h0f, 1'h1);
		sums();
		op(1'h1, 8'h7e, 8'h00);
		chk("crc other page", r, 8'h00);
		op(1'h0, 8'h00, 8'h00);
		wf(8'h30, 8'h5a, 1'h0);
		sums();
		op(1'h1, 8'h7d, 8'h00);
		chk("xor read", r, ex);
		op(1'h1, 8'h7e, 8'h00);
		chk("crc page zero", r, ec);
		repeat (4) op(1'h0, 8'h7d, 8'h00);
		ex = 8'h00;
		sums();
		op(1'h0, 8'h7f, 8'h05);
		op(1'h0, 8'h00, 8'h01);
		wf(8'h20, 8'h77, 1'h0);
		sums();
		op(1'h0, 8'h7f, 8'h00);
		op(1'h0, 8'h00, 8'h00);
		for (int i = 0; i < 3; i++) begin
			op(1'h0, 8'h02, pw[i]);
			chk("power", {30'h0, standby, power_down}, {30'h0, pw[i][4], pw[i][0]});
			nm = n_mod;
			op(1'h0, 8'h01, 8'h10);
			chk("mod pulses", n_mod - nm, (pw[i] == 8'h10) ? 1 : 0);
			chk("refused", {31'h0, q[1]}, (pw[i] == 8'h10) ? 32'h0 : 32'h1);
			apb(1'h1, 12'h004, 32'h2);
			nm = n_reg;
			op(1'h0, 8'h01, 8'h01);
			chk("reg pulses", n_reg - nm, 1);
			chk("refused cleared", {31'h0, q[1]}, 32'h0);
			chk("power cleared", {30'h0, standby, power_down}, 32'h0);
		end
		apb(1'h1, 12'h000, {16'h0000, 8'h00, 8'h7e});
		op(1'h0, 8'h10, 8'h99);
		ec = 8'h00;
		sums();
		chk("busy refused", {31'h0, q[1]}, 32'h1);
		nm = n_reg;
		op(1'h0, 8'h01, 8'h01);
		chk("reg refused", n_reg - nm, 0);
		end_of_test();
	end
endmodule

// ===== bench/rwcs_assertions.sv
// link checker: handshake timing and read values against a checksum model
// assumes plain inputs tied to the interface between host and device
`timescale 1ns/1ps
module rwcs_assertions (
	input wire logic link_clk,
	input wire logic presetn,
	input wire logic req_tgl,
	input wire logic rd,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack_tgl
);
	logic ack_q;
	logic [7:0] book_reg;
	logic [7:0] page_reg;
	logic [7:0] crc_reg;
	logic [7:0] xor_reg;
	logic [1:0] warm_reg;
	wire done = ack_tgl != ack_q;
	wire wev = done && !rd;
	wire rev = done && rd;
	wire base = book_reg == 8'h00 && page_reg == 8'h00;
	wire sel = addr == 8'h7f || addr == 8'h00;
	wire crc_loc = addr == 8'h7e && (book_reg == 8'h00 || page_reg == 8'h00);
	wire xor_loc = addr == 8'h7d && book_reg == 8'h8c && page_reg == 8'h00;
	wire fold = wev && !sel && !crc_loc && !xor_loc;
	wire xfold = fold && book_reg == 8'h8c && page_reg != 8'h00;
	wire regs_clr = wev && addr == 8'h01 && base && wdata[0];

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] v;
		v = c ^ b;
		for (int i = 0; i < 8; i++) v = v[7] ? {v[6:0], 1'h0} ^ 8'h07 : {v[6:0], 1'h0};
		return v;
	endfunction

	// ----------------------------------------------------------------
	// reference of book, page and both checksums
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'h0;
			warm_reg <= 2'h0;
			book_reg <= 8'h00;
			page_reg <= 8'h00;
			crc_reg <= 8'h00;
			xor_reg <= 8'h00;
		end else begin
			ack_q <= ack_tgl;
			warm_reg <= {warm_reg[0], 1'h1};
			book_reg <= regs_clr ? 8'h00 : (wev && addr == 8'h7f) ? wdata : book_reg;
			page_reg <= regs_clr ? 8'h00 : (wev && addr == 8'h00) ? wdata : page_reg;
			crc_reg <= (wev && crc_loc) ? wdata : fold ? crc8(crc_reg, wdata) : crc_reg;
			xor_reg <= (wev && xor_loc) ? wdata : xfold ? xor_reg ^ wdata : xor_reg;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge link_clk); endclocking
	// checks wait two link ticks so that $past never reaches back before reset
	default disable iff (!presetn || !warm_reg[1]);
	a_ack_in_time: assert property ($changed(req_tgl) |-> ##[1:8] $changed(ack_tgl))
		else $error("answer toggle late");
	a_ack_needs_req: assert property ($changed(ack_tgl) |-> $past(req_tgl != ack_tgl))
		else $error("answer without request");
	a_req_waits_ack: assert property ($changed(req_tgl) |-> $past(req_tgl == ack_tgl))
		else $error("request while one outstanding");
	a_cmd_held: assert property ((req_tgl != ack_tgl) && $past(req_tgl != ack_tgl)
		|-> $stable({rd, addr, wdata})) else $error("command changed while outstanding");
	a_rdata_held: assert property ((req_tgl == ack_tgl) && $past(req_tgl == ack_tgl)
		|-> $stable(rdata)) else $error("read data changed while idle");
	a_crc_read: assert property (rev && crc_loc |-> rdata == crc_reg)
		else $error("crc read mismatch");
	a_xor_read: assert property (rev && xor_loc |-> rdata == xor_reg)
		else $error("xor read mismatch");
	a_select_read: assert property (rev && sel
		|-> rdata == (addr == 8'h7f ? book_reg : page_reg)) else $error("select read mismatch");
	a_other_zero: assert property (rev && !sel && !crc_loc && !xor_loc
		&& !(addr == 8'h02 && base) |-> rdata == 8'h00) else $error("other read not zero");
endmodule

// ===== common/rwcs_defines.svh
// constants shared by both ends of the register write checksum link
// assumes 8-bit register addresses and data on the link, 32-bit apb
`ifndef RWCS_DEFINES_SVH
`define RWCS_DEFINES_SVH

// ----------------------------------------------------------------
// device register map
// ----------------------------------------------------------------
`define RWCS_A_PAGE_SEL 8'h00
`define RWCS_A_BOOK_SEL 8'h7f
`define RWCS_A_CRC 8'h7e
`define RWCS_A_XOR 8'h7d
`define RWCS_A_RESET 8'h01
`define RWCS_A_POWER 8'h02
`define RWCS_BOOK_BASE 8'h00
`define RWCS_BOOK_COEF 8'h8c
`define RWCS_PAGE_BASE 8'h00
`define RWCS_CRC_POLY 8'h07
`define RWCS_CRC_INIT 8'h00
`define RWCS_XOR_INIT 8'h00
`define RWCS_RST_REG_BIT 0
`define RWCS_RST_MOD_BIT 4
`define RWCS_PWR_DOWN_BIT 0
`define RWCS_PWR_STBY_BIT 4

// ----------------------------------------------------------------
// host apb map and fields
// ----------------------------------------------------------------
`define RWCS_APB_CMD 12'h000
`define RWCS_APB_STAT 12'h004
`define RWCS_CMD_ADDR_LSB 0
`define RWCS_CMD_DATA_LSB 8
`define RWCS_CMD_RD_BIT 16
`define RWCS_ST_BUSY_BIT 0
`define RWCS_ST_REFUSED_BIT 1
`define RWCS_ST_RDATA_LSB 8
`define RWCS_LINK_HALF 2

`endif

// ===== common/rwcs_if.sv
// link between the register host and the checksum device
// assumes the host makes link_clk from its own clock
`timescale 1ns/1ps
interface rwcs_if;
	logic link_clk;
	logic req_tgl;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack_tgl;
	modport dev (
		input link_clk,
		input req_tgl,
		input rd,
		input addr,
		input wdata,
		output rdata,
		output ack_tgl
	);
	modport host (
		output link_clk,
		output req_tgl,
		output rd,
		output addr,
		output wdata,
		input rdata,
		input ack_tgl
	);
endinterface

// ===== common/rwcs_pkg.sv
// types used by the register host end of the checksum link
// assumes rwcs_defines.svh for numeric constants
package rwcs_pkg;
	typedef enum logic [3:0] {
		RWCS_H_IDLE = 4'b0001,
		RWCS_H_SETUP = 4'b0010,
		RWCS_H_WAIT = 4'b0100,
		RWCS_H_DONE = 4'b1000
	} rwcs_host_state_t;
endpackage

// ===== rtl/rwcs_device.sv
// register write checksum device: book/page registers, crc and xor checksums
// assumes link_clk runs freely from the host; presetn asynchronous, active low
`timescale 1ns/1ps
`include "rwcs_defines.svh"
module rwcs_device (
	rwcs_if.dev lnk,
	input wire logic presetn,
	output logic standby,
	output logic power_down,
	output logic reg_reset_pulse,
	output logic mod_reset_pulse,
	output logic [7:0] crc_value,
	output logic [7:0] xor_value
);

	// ----------------------------------------------------------------
	// crc step
	// ----------------------------------------------------------------
	// msb first step
	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `RWCS_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [17:0] sync1_reg;
	logic [17:0] sync2_reg;
	logic req_seen_reg;
	always_ff @(posedge lnk.link_clk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {lnk.req_tgl, lnk.rd, lnk.addr, lnk.wdata};
			sync2_reg <= sync1_reg;
		end
	end

	wire req_s = sync2_reg[17];
	wire rd_s = sync2_reg[16];
	wire [7:0] addr_s = sync2_reg[15:8];
	wire [7:0] data_s = sync2_reg[7:0];
	wire go = req_s != req_seen_reg;
	wire wr_go = go && !rd_s;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [7:0] book_reg;
	logic [7:0] page_reg;
	logic [7:0] power_reg;
	logic [7:0] crc_reg;
	logic [7:0] xor_reg;
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic ack_pend_reg;

	wire is_book_sel = addr_s == `RWCS_A_BOOK_SEL;
	wire is_page_sel = addr_s == `RWCS_A_PAGE_SEL;
	wire book_base = book_reg == `RWCS_BOOK_BASE;
	wire book_coef = book_reg == `RWCS_BOOK_COEF;
	wire page_base = page_reg == `RWCS_PAGE_BASE;
	wire crc_loc = (addr_s == `RWCS_A_CRC) && (book_base || page_base);
	wire xor_loc = (addr_s == `RWCS_A_XOR) && book_coef && page_base;
	wire base_loc = book_base && page_base;
	wire is_reset = base_loc && (addr_s == `RWCS_A_RESET);
	wire is_power = base_loc && (addr_s == `RWCS_A_POWER);
	wire is_switch = is_book_sel || is_page_sel;
	wire fold = wr_go && !is_switch && !crc_loc && !xor_loc;
	wire xor_fold = fold && book_coef && !page_base;
	wire reg_rst = wr_go && is_reset && data_s[`RWCS_RST_REG_BIT];
	wire mod_rst = wr_go && is_reset && data_s[`RWCS_RST_MOD_BIT];

	wire [7:0] rd_mux = crc_loc ? crc_reg :
		xor_loc ? xor_reg :
		is_book_sel ? book_reg :
		is_page_sel ? page_reg :
		is_power ? power_reg : 8'h00;

	// ----------------------------------------------------------------
	// register file and checksums
	// ----------------------------------------------------------------
	always_ff @(posedge lnk.link_clk or negedge presetn) begin
		if (!presetn) begin
			book_reg <= 8'h00;
			page_reg <= 8'h00;
			power_reg <= 8'h00;
		end else if (reg_rst) begin
			book_reg <= 8'h00;
			page_reg <= 8'h00;
			power_reg <= 8'h00;
		end else if (wr_go) begin
			if (is_book_sel) begin
				book_reg <= data_s;
			end else if (is_page_sel) begin
				page_reg <= data_s;
			end else if (is_power) begin
				power_reg <= data_s;
			end
		end
	end

	always_ff @(posedge lnk.link_clk or negedge presetn) begin
		if (!presetn) begin
			crc_reg <= `RWCS_CRC_INIT;
			xor_reg <= `RWCS_XOR_INIT;
		end else begin
			if (wr_go && crc_loc) begin
				crc_reg <= data_s;
			end else if (fold) begin
				crc_reg <= crc_byte(crc_reg, data_s);
			end
			if (wr_go && xor_loc) begin
				xor_reg <= data_s;
			end else if (xor_fold) begin
				xor_reg <= xor_reg ^ data_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// answer: data first, ack toggle one link cycle later
	// ----------------------------------------------------------------
	always_ff @(posedge lnk.link_clk or negedge presetn) begin
		if (!presetn) begin
			req_seen_reg <= 1'b0;
			rdata_reg <= 8'h00;
			ack_pend_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else begin
			req_seen_reg <= req_s;
			ack_pend_reg <= go;
			if (go && rd_s) begin
				rdata_reg <= rd_mux;
			end
			if (ack_pend_reg) begin
				ack_reg <= !ack_reg;
			end
		end
	end
	assign lnk.rdata = rdata_reg;
	assign lnk.ack_tgl = ack_reg;

	// ----------------------------------------------------------------
	// user side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge lnk.link_clk or negedge presetn) begin
		if (!presetn) begin
			reg_reset_pulse <= 1'b0;
			mod_reset_pulse <= 1'b0;
			standby <= 1'b0;
			power_down <= 1'b0;
			crc_value <= 8'h00;
			xor_value <= 8'h00;
		end else begin
			reg_reset_pulse <= reg_rst;
			mod_reset_pulse <= mod_rst;
			standby <= power_reg[`RWCS_PWR_STBY_BIT];
			power_down <= power_reg[`RWCS_PWR_DOWN_BIT];
			crc_value <= crc_reg;
			xor_value <= xor_reg;
		end
	end

endmodule

// ===== rtl/rwcs_host.sv
// register host: apb slave that issues single-byte link transfers
// assumes apb master on pclk; the device samples the link with its own synchronisers
`timescale 1ns/1ps
`include "rwcs_defines.svh"
module rwcs_host #(
	parameter int LINK_HALF = `RWCS_LINK_HALF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	rwcs_if.host lnk
);

	generate
		if (LINK_HALF < 1 || LINK_HALF > 255) begin : g_bad_half
			$error("LINK_HALF out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// link clock divider
	// ----------------------------------------------------------------
	logic [7:0] div_reg;
	logic lclk_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 8'h00;
			lclk_reg <= 1'b0;
		end else if (div_reg == 8'(LINK_HALF - 1)) begin
			div_reg <= 8'h00;
			lclk_reg <= !lclk_reg;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign lnk.link_clk = lclk_reg;

	// ----------------------------------------------------------------
	// answer synchronisers
	// ----------------------------------------------------------------
	logic [8:0] s1_reg;
	logic [8:0] s2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {lnk.ack_tgl, lnk.rdata};
			s2_reg <= s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb decode and reset-sequence guard
	// ----------------------------------------------------------------
	rwcs_pkg::rwcs_host_state_t st_reg;
	logic [7:0] book_sh_reg;
	logic [7:0] page_sh_reg;
	logic stby_sh_reg;
	logic pd_sh_reg;
	logic refused_reg;
	logic req_reg;
	logic ack_seen_reg;
	logic rd_reg;
	logic [7:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;

	wire acc = psel && penable && pready;
	wire wr_cmd = acc && pwrite && (paddr == `RWCS_APB_CMD);
	wire wr_stat = acc && pwrite && (paddr == `RWCS_APB_STAT);
	wire mapped = (paddr == `RWCS_APB_CMD) || (paddr == `RWCS_APB_STAT);
	wire idle = st_reg == rwcs_pkg::RWCS_H_IDLE;
	wire [7:0] c_addr = pwdata[`RWCS_CMD_ADDR_LSB +: 8];
	wire [7:0] c_data = pwdata[`RWCS_CMD_DATA_LSB +: 8];
	wire c_rd = pwdata[`RWCS_CMD_RD_BIT];
	wire base_sel = (book_sh_reg == `RWCS_BOOK_BASE) && (page_sh_reg == `RWCS_PAGE_BASE);
	wire c_rst = !c_rd && base_sel && (c_addr == `RWCS_A_RESET);
	wire c_mod = c_rst && c_data[`RWCS_RST_MOD_BIT];
	wire c_regr = c_rst && c_data[`RWCS_RST_REG_BIT];
	// modules alone only from standby without power-down; registers, with or without modules, from standby or power-down
	wire bad_mod = c_mod && !c_regr && (!stby_sh_reg || pd_sh_reg);
	wire bad_reg = c_regr && !stby_sh_reg && !pd_sh_reg;
	wire refuse = wr_cmd && (!idle || bad_mod || bad_reg);
	wire launch = wr_cmd && idle && !bad_mod && !bad_reg;
	wire ack_new = s2_reg[8] != ack_seen_reg;
	wire [31:0] stat_word = {16'h0000, rdata_reg, 6'h00, refused_reg, !idle};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				prdata <= (paddr == `RWCS_APB_STAT) ? stat_word :
					(paddr == `RWCS_APB_CMD) ? {15'h0000, rd_reg, wdata_reg, addr_reg} :
					32'h00000000;
			end
		end
	end

	// set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused_reg <= 1'b0;
		end else if (refuse) begin
			refused_reg <= 1'b1;
		end else if (wr_stat && pwdata[`RWCS_ST_REFUSED_BIT]) begin
			refused_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transfer sequencer and device-state shadow
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= rwcs_pkg::RWCS_H_IDLE;
			req_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			book_sh_reg <= 8'h00;
			page_sh_reg <= 8'h00;
			stby_sh_reg <= 1'b0;
			pd_sh_reg <= 1'b0;
		end else begin
			case (st_reg)
				rwcs_pkg::RWCS_H_IDLE: begin
					if (launch) begin
						rd_reg <= c_rd;
						addr_reg <= c_addr;
						wdata_reg <= c_data;
						st_reg <= rwcs_pkg::RWCS_H_SETUP;
					end
				end
				rwcs_pkg::RWCS_H_SETUP: begin
					req_reg <= !req_reg;
					st_reg <= rwcs_pkg::RWCS_H_WAIT;
				end
				rwcs_pkg::RWCS_H_WAIT: begin
					if (ack_new) begin
						ack_seen_reg <= s2_reg[8];
						rdata_reg <= s2_reg[7:0];
						st_reg <= rwcs_pkg::RWCS_H_DONE;
					end
				end
				rwcs_pkg::RWCS_H_DONE: begin
					st_reg <= rwcs_pkg::RWCS_H_IDLE;
					if (!rd_reg) begin
						if (addr_reg == `RWCS_A_BOOK_SEL) begin
							book_sh_reg <= wdata_reg;
						end else if (addr_reg == `RWCS_A_PAGE_SEL) begin
							page_sh_reg <= wdata_reg;
						end else if (base_sel && addr_reg == `RWCS_A_POWER) begin
							stby_sh_reg <= wdata_reg[`RWCS_PWR_STBY_BIT];
							pd_sh_reg <= wdata_reg[`RWCS_PWR_DOWN_BIT];
						end else if (base_sel && addr_reg == `RWCS_A_RESET &&
							wdata_reg[`RWCS_RST_REG_BIT]) begin
							book_sh_reg <= 8'h00;
							page_sh_reg <= 8'h00;
							stby_sh_reg <= 1'b0;
							pd_sh_reg <= 1'b0;
						end
					end
				end
				default: begin
					st_reg <= rwcs_pkg::RWCS_H_IDLE;
				end
			endcase
		end
	end

	assign lnk.req_tgl = req_reg;
	assign lnk.rd = rd_reg;
	assign lnk.addr = addr_reg;
	assign lnk.wdata = wdata_reg;

endmodule
